// [logic/dtbs_core.sv]
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// How it works
// - even host part, odd controller part
// - type bit set copies config across
// - null frame leaves status untouched
// - zero frame id means ignored
// - controller status writes are dropped
// - no host lock during swap/copy
// - no lock while host and controller parts both committed
// - commit+unlock triggers swap then copy
// - copy back header, data, slot status
// - event flag after controller part sent
// - transmit while host edits host part
// - addresses fixed, contents swap internally
// - write lock one, read one acknowledges
// - unlock with commit clears event, sets valid
// - host commit reads one until done
// - internal lock before transmitting
// - tx end updates commit/valid/event
// - slot status kept for both parts
// - configured pair enables transmit
module dtbs_core #(
  parameter int DATA_WORDS = 32
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // frame engine side
  input  wire logic        tx_req,
  input  wire logic        tx_null,
  input  wire logic        tx_done,
  input  wire logic [5:0]  tx_rd_idx,
  input  wire logic        sts_we,
  input  wire logic        sts_ctrl,
  input  wire logic [31:0] sts_val,
  output logic             tx_grant,
  output logic             tx_locked,
  output logic      [31:0] tx_rd_data,
  output logic             tx_capable,
  // status levels
  output logic             host_evt,
  output logic             ctrl_evt,
  output logic             swap_busy
);
  localparam int WORDS = DATA_WORDS + 3;
  localparam logic [5:0] LAST_IDX = 6'(WORDS - 1);

  // ----------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------
  generate
    if (DATA_WORDS < 1 || DATA_WORDS > 61) begin : g_bad
      $error("DATA_WORDS must be 1..61");
    end
  endgenerate

  // ----------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------
  // even/odd part pair
  logic [31:0]          mem [0:127];
  logic                 sel_r;
  logic [1:0]           idnz_r;
  logic [7:0]           hcs_r, hcs_nxt;
  logic [7:0]           ccs_r, ccs_nxt;
  logic                 lock_r, lock_nxt;
  logic                 txl_r, txl_nxt;
  dtbs_pkg::dtbs_state_t st_r, st_nxt;
  logic [5:0]           cnt_r;
  logic                 a_wr_r, a_rd_r;
  logic [11:0]          a_addr_r;
  logic [31:0]          hrdata_r;
  logic                 hreadyout_r;
  logic                 tx_grant_r, tx_capable_r, busy_r;
  logic [31:0]          tx_rd_data_r;

  // host-visible word slot for an address, out of range flagged
  function automatic logic [6:0] host_idx(input logic [11:0] a);
    logic [6:0] r;
    r = 7'h40;
    if (a[9:8] == dtbs_pkg::RGN_REGS && a[11:10] == 2'h0) begin
      if (a[7:0] == dtbs_pkg::OFS_HDR[7:0]) r = {1'b0, dtbs_pkg::IDX_HDR};
      if (a[7:0] == dtbs_pkg::OFS_CRC[7:0]) r = {1'b0, dtbs_pkg::IDX_CRC};
      if (a[7:0] == dtbs_pkg::OFS_SSV[7:0]) r = {1'b0, dtbs_pkg::IDX_SSV};
    end else if (a[9:8] == dtbs_pkg::RGN_HDATA && a[11:10] == 2'h0 &&
                 32'(a[7:2]) < DATA_WORDS) begin
      r = {1'b0, a[7:2] + dtbs_pkg::IDX_DATA};
    end
    return r;
  endfunction

  // ----------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------
  wire        acc      = hsel & htrans[1] & hready;
  wire [6:0]  w_hidx   = host_idx(a_addr_r);
  wire        w_hvalid = ~w_hidx[6];
  wire        is_csh   = a_addr_r == dtbs_pkg::OFS_CS_HOST;
  wire        is_csc   = a_addr_r == dtbs_pkg::OFS_CS_CTRL;
  wire        is_cview = a_addr_r[11:8] == {2'h0, dtbs_pkg::RGN_CVIEW} &&
                         32'(a_addr_r[7:2]) < WORDS;
  wire        wr_csh   = a_wr_r & is_csh;
  wire        idle     = st_r == dtbs_pkg::ST_IDLE;
  wire        is_hdr   = w_hidx[5:0] == dtbs_pkg::IDX_HDR;
  // header may be set up unlocked in idle as configuration
  wire        cfg_hdr  = a_wr_r & w_hvalid & is_hdr & idle & ~lock_r;
  // slot status is engine-owned; host writes it never
  wire        host_we  = a_wr_r & w_hvalid & (w_hidx[5:0] != dtbs_pkg::IDX_SSV) &
                         (lock_r | cfg_hdr);
  wire        cfg_copy = cfg_hdr & hcs_r[dtbs_pkg::CS_BT];
  wire        wr_id_nz = hwdata[dtbs_pkg::HDR_ID_W-1:dtbs_pkg::HDR_ID_LSB] != 11'h000;
  wire [31:0] ctrl_hdr = mem[{~sel_r, dtbs_pkg::IDX_HDR}];

  // ----------------------------------------------------------
  // lock and transmit qualifiers
  // ----------------------------------------------------------
  // nonzero id only
  wire host_cfg_ok = hcs_r[dtbs_pkg::CS_BT] & idnz_r[sel_r];
  wire ctrl_cfg_ok = ccs_r[dtbs_pkg::CS_BT] & idnz_r[~sel_r];
  wire lock_wr     = wr_csh & hwdata[dtbs_pkg::CS_LOCK];
  wire grant_lock  = lock_wr & ~lock_r & idle & host_cfg_ok &
                     ~(hcs_r[dtbs_pkg::CS_COMMIT] & ccs_r[dtbs_pkg::CS_COMMIT]);
  wire unlock      = lock_wr & lock_r;
  wire tx_ok       = ccs_r[dtbs_pkg::CS_VALID] & ccs_r[dtbs_pkg::CS_COMMIT] &
                     ctrl_cfg_ok & (st_r != dtbs_pkg::ST_SWAP) &
                     (ctrl_hdr[dtbs_pkg::HDR_ID_W-1:0] != 11'h000);

  // ----------------------------------------------------------
  // control/status next values and sequencing
  // ----------------------------------------------------------
  always_comb begin
    hcs_nxt  = hcs_r;
    ccs_nxt  = ccs_r;
    lock_nxt = lock_r;
    txl_nxt  = txl_r;
    st_nxt   = st_r;
    if (wr_csh && idle && !lock_r) begin
      hcs_nxt = (hcs_r & ~dtbs_pkg::CS_CFG_MASK) | (hwdata[7:0] & dtbs_pkg::CS_CFG_MASK);
      if (hwdata[dtbs_pkg::CS_BT]) begin
        ccs_nxt = (ccs_r & ~dtbs_pkg::CS_CFG_MASK) | (hwdata[7:0] & dtbs_pkg::CS_CFG_MASK);
      end
    end
    // event flag cleared by writing one
    if (wr_csh && hwdata[dtbs_pkg::CS_EVT]) begin
      hcs_nxt[dtbs_pkg::CS_EVT] = 1'b0;
    end
    if (wr_csh && lock_r) begin
      hcs_nxt[dtbs_pkg::CS_COMMIT] = hwdata[dtbs_pkg::CS_COMMIT];
    end
    if (grant_lock) begin
      lock_nxt = 1'b1;
    end
    if (unlock) begin
      lock_nxt = 1'b0;
      if (hcs_nxt[dtbs_pkg::CS_COMMIT]) begin
        hcs_nxt[dtbs_pkg::CS_VALID] = 1'b1;
        hcs_nxt[dtbs_pkg::CS_EVT]   = 1'b0;
        st_nxt                      = dtbs_pkg::ST_WAIT;
      end
    end
    if (tx_req && !txl_r && tx_ok) begin
      txl_nxt = 1'b1;
    end
    if (tx_null && txl_r) begin
      txl_nxt = 1'b0;
    end
    if (tx_done && txl_r && !tx_null) begin
      txl_nxt                      = 1'b0;
      ccs_nxt[dtbs_pkg::CS_COMMIT] = 1'b0;
      ccs_nxt[dtbs_pkg::CS_EVT]    = 1'b1;
      if (ccs_r[dtbs_pkg::CS_TT]) begin
        ccs_nxt[dtbs_pkg::CS_VALID] = 1'b0;
      end
    end
    case (st_r)
      dtbs_pkg::ST_WAIT: begin
        // swap only once the old frame left and no frame is in flight
        if (!ccs_nxt[dtbs_pkg::CS_COMMIT] && !txl_r) begin
          st_nxt = dtbs_pkg::ST_SWAP;
        end
      end
      dtbs_pkg::ST_SWAP: begin
        hcs_nxt = ccs_r;
        ccs_nxt = hcs_r;
        hcs_nxt[dtbs_pkg::CS_COMMIT] = 1'b1;
        st_nxt                       = dtbs_pkg::ST_COPY;
      end
      dtbs_pkg::ST_COPY: begin
        if (cnt_r == LAST_IDX) begin
          hcs_nxt[dtbs_pkg::CS_COMMIT] = 1'b0;
          st_nxt                       = dtbs_pkg::ST_IDLE;
        end
      end
      dtbs_pkg::ST_IDLE: begin
        st_nxt = st_nxt;
      end
      default: begin
        st_nxt = dtbs_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------
  // read mux
  // ----------------------------------------------------------
  wire [7:0]  csh_rd  = {hcs_r[7:1], lock_r};
  wire [7:0]  csc_rd  = {ccs_r[7:1], txl_r};
  wire [31:0] hmem_rd = mem[{sel_r, w_hidx[5:0]}];
  wire [31:0] cmem_rd = mem[{~sel_r, a_addr_r[7:2]}];
  wire [31:0] rd_val  = is_csh   ? {24'h000000, csh_rd} :
                        is_csc   ? {24'h000000, csc_rd} :
                        w_hvalid ? hmem_rd :
                        is_cview ? cmem_rd : 32'h00000000;

  // ----------------------------------------------------------
  // ahb address and data phase
  // ----------------------------------------------------------
  // reads take one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr_r      <= 1'b0;
      a_rd_r      <= 1'b0;
      a_addr_r    <= 12'h000;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
    end else begin
      a_wr_r <= acc & hwrite & (hsize == 3'h2);
      if (acc) begin
        a_addr_r <= haddr[11:0];
      end
      if (acc && !hwrite) begin
        a_rd_r      <= 1'b1;
        hreadyout_r <= 1'b0;
      end else if (a_rd_r) begin
        a_rd_r      <= 1'b0;
        hrdata_r    <= rd_val;
        hreadyout_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcs_r  <= dtbs_pkg::CS_RESET;
      ccs_r  <= dtbs_pkg::CS_RESET;
      lock_r <= 1'b0;
      txl_r  <= 1'b0;
      st_r   <= dtbs_pkg::ST_IDLE;
    end else begin
      hcs_r  <= hcs_nxt;
      ccs_r  <= ccs_nxt;
      lock_r <= lock_nxt;
      txl_r  <= txl_nxt;
      st_r   <= st_nxt;
    end
  end

  // swap by bank pointer, addresses fixed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_r  <= 1'b0;
      cnt_r  <= 6'h00;
      idnz_r <= 2'b00;
    end else begin
      if (st_r == dtbs_pkg::ST_SWAP) begin
        sel_r <= ~sel_r;
      end
      cnt_r <= (st_r == dtbs_pkg::ST_COPY) ? cnt_r + 6'h01 : 6'h00;
      if (host_we && is_hdr) begin
        idnz_r[sel_r] <= wr_id_nz;
      end
      if (cfg_copy) begin
        idnz_r[~sel_r] <= wr_id_nz;
      end
      if (st_r == dtbs_pkg::ST_COPY && cnt_r == 6'h00) begin
        idnz_r[sel_r] <= idnz_r[~sel_r];
      end
    end
  end

  // ----------------------------------------------------------
  // message memory, two parts selected by sel_r
  // ----------------------------------------------------------
  // later writes win: engine slot status beats the copy
  always_ff @(posedge hclk) begin
    if (host_we) begin
      mem[{sel_r, w_hidx[5:0]}] <= hwdata;
    end
    if (cfg_copy) begin
      mem[{~sel_r, dtbs_pkg::IDX_HDR}] <= hwdata;
    end
    if (st_r == dtbs_pkg::ST_COPY) begin
      mem[{sel_r, cnt_r}] <= mem[{~sel_r, cnt_r}];
    end
    if (sts_we) begin
      mem[{sel_r ^ sts_ctrl, dtbs_pkg::IDX_SSV}] <= sts_val;
    end
  end

  // ----------------------------------------------------------
  // engine-facing outputs
  // ----------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_grant_r   <= 1'b0;
      tx_rd_data_r <= 32'h00000000;
      tx_capable_r <= 1'b0;
      busy_r       <= 1'b0;
    end else begin
      tx_grant_r   <= txl_nxt & ~txl_r;
      tx_rd_data_r <= mem[{~sel_r, tx_rd_idx}];
      tx_capable_r <= ctrl_cfg_ok;
      busy_r       <= st_nxt != dtbs_pkg::ST_IDLE;
    end
  end

  assign hrdata     = hrdata_r;
  assign hreadyout  = hreadyout_r;
  assign hresp      = 1'b0;
  assign tx_grant   = tx_grant_r;
  assign tx_locked  = txl_r;
  assign tx_rd_data = tx_rd_data_r;
  assign tx_capable = tx_capable_r;
  assign host_evt   = hcs_r[dtbs_pkg::CS_EVT];
  assign ctrl_evt   = ccs_r[dtbs_pkg::CS_EVT];
  assign swap_busy  = busy_r;
endmodule // dtbs_core

// [logic/dtbs_pkg.sv]
package dtbs_pkg;
  // ----------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------
  localparam logic [11:0] OFS_CS_HOST = 12'h000;
  localparam logic [11:0] OFS_CS_CTRL = 12'h004;
  localparam logic [11:0] OFS_HDR     = 12'h008;
  localparam logic [11:0] OFS_CRC     = 12'h00c;
  localparam logic [11:0] OFS_SSV     = 12'h010;
  localparam logic [1:0]  RGN_REGS    = 2'h0;
  localparam logic [1:0]  RGN_HDATA   = 2'h1;
  localparam logic [1:0]  RGN_CVIEW   = 2'h2;

  // ----------------------------------------------------------
  // control/status field positions
  // ----------------------------------------------------------
  localparam int CS_LOCK   = 0;
  localparam int CS_COMMIT = 1;
  localparam int CS_VALID  = 2;
  localparam int CS_EVT    = 3;
  localparam int CS_BT     = 4;
  localparam int CS_TT     = 5;
  localparam int CS_CHA    = 6;
  localparam int CS_CHB    = 7;
  localparam logic [7:0] CS_CFG_MASK = 8'hf0;
  localparam logic [7:0] CS_RESET    = 8'h00;

  // ----------------------------------------------------------
  // header word layout and word slots inside a part
  // ----------------------------------------------------------
  localparam int HDR_ID_LSB  = 0;
  localparam int HDR_ID_W    = 11;
  localparam int HDR_LEN_LSB = 16;
  localparam int HDR_PRE     = 30;
  localparam int HDR_RSV     = 31;
  localparam logic [5:0] IDX_HDR  = 6'h00;
  localparam logic [5:0] IDX_CRC  = 6'h01;
  localparam logic [5:0] IDX_SSV  = 6'h02;
  localparam logic [5:0] IDX_DATA = 6'h03;

  // ----------------------------------------------------------
  // pair sequencing states
  // ----------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_SWAP = 4'h4,
    ST_COPY = 4'h8
  } dtbs_state_t;
endpackage

// [testbench/dtbs_core_properties.sv]
`timescale 1ns/1ps
// ------------------------------------------
// port checks for the double buffer swap
// ------------------------------------------
module dtbs_core_properties #(
  parameter int DATA_WORDS = 32
) (
  // clock, reset and bus
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize,
  // frame engine side
  input wire logic        tx_req, tx_null, tx_done, sts_we, sts_ctrl,
  input wire logic [5:0]  tx_rd_idx,
  input wire logic [31:0] sts_val, tx_rd_data,
  input wire logic        tx_grant, tx_locked, tx_capable, host_evt, ctrl_evt, swap_busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // engine lock handshake and bus read wait state
  a_grant_after_req: assert property (tx_grant |-> $past(tx_req) && tx_locked)
    else $error("grant without a request");
  a_grant_one_pulse: assert property (tx_grant |=> !tx_grant)
    else $error("grant longer than one cycle");
  a_lock_holds: assert property (tx_locked && !tx_done && !tx_null |=> tx_locked)
    else $error("internal lock dropped early");
  a_done_sets_evt: assert property (tx_locked && tx_done && !tx_null |=> !tx_locked && ctrl_evt)
    else $error("sent frame did not update status");
  a_null_keeps_sts: assert property (tx_locked && tx_null |=> !tx_locked && $stable(ctrl_evt))
    else $error("null frame changed status");
  a_grant_needs_cfg: assert property (tx_grant |-> $past(tx_capable))
    else $error("grant on unconfigured part");
  a_evt_after_tx: assert property ($rose(ctrl_evt) |-> $past(tx_done) && $past(tx_locked))
    else $error("event flag without a sent frame");
  a_read_wait_one: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not one cycle");

  // main scenarios seen
  c_grant: cover property (tx_grant);
  c_null: cover property (tx_locked && tx_null);
  c_swap_end: cover property ($fell(swap_busy));
endmodule // dtbs_core_properties

bind dtbs_core dtbs_core_properties #(.DATA_WORDS(DATA_WORDS)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans), .hsize(hsize),
  .tx_req(tx_req), .tx_null(tx_null), .tx_done(tx_done), .sts_we(sts_we), .sts_ctrl(sts_ctrl),
  .tx_rd_idx(tx_rd_idx), .sts_val(sts_val), .tx_rd_data(tx_rd_data), .tx_grant(tx_grant),
  .tx_locked(tx_locked), .tx_capable(tx_capable), .host_evt(host_evt), .ctrl_evt(ctrl_evt),
  .swap_busy(swap_busy));

// [testbench/dtbs_engine_model.sv]
`timescale 1ns/1ps
// ------------------------------------------
// frame engine stand-in, controller side
// ------------------------------------------
module dtbs_engine_model (
  // clock, reset and bench control
  input wire logic        hclk, hresetn, go, as_null,
  input wire logic [7:0]  hold_cyc,
  // controller part port
  input wire logic        tx_grant,
  input wire logic [31:0] tx_rd_data,
  output logic            tx_req, tx_null, tx_done, sts_we, sts_ctrl, busy,
  output logic [5:0]      tx_rd_idx,
  output logic [31:0]     sts_val, got_hdr, got_d0
);
  logic [1:0] st_r;
  logic [7:0] cnt_r;

  always @(posedge hclk) begin
    tx_req <= 1'b0;
    tx_done <= 1'b0;
    tx_null <= 1'b0;
    sts_we <= 1'b0;
    // quiet values while reset holds; one process drives every output
    if (!hresetn) begin
      {sts_ctrl, busy, st_r, cnt_r} <= '0;
      {tx_rd_idx, sts_val, got_hdr, got_d0} <= '0;
    end else begin
      case (st_r)
        2'h0: if (go) begin
          tx_req <= 1'b1;
          busy <= 1'b1;
          st_r <= 2'h1;
        end
        // no timeout here: a refused request hangs until the bench cuts it
        2'h1: if (tx_grant) begin
          cnt_r <= 8'h00;
          tx_rd_idx <= 6'h00;
          st_r <= 2'h2;
        end
        2'h2: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'h03) got_hdr <= tx_rd_data;
          if (cnt_r == 8'h03) tx_rd_idx <= 6'h03;
          if (cnt_r == 8'h06) got_d0 <= tx_rd_data;
          if (cnt_r == hold_cyc) begin
            tx_done <= !as_null;
            tx_null <= as_null;
            sts_we <= 1'b1;
            sts_ctrl <= hold_cyc[0];
            sts_val <= {24'h5a5a5a, hold_cyc};
            st_r <= 2'h3;
          end
        end
        default: begin
          busy <= 1'b0;
          st_r <= 2'h0;
        end
      endcase
    end
  end
endmodule // dtbs_engine_model

// [testbench/tb_double_tx_buffer_swap.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
// ------------------------------------------
// bench for the double buffer swap
// ------------------------------------------
module tb_double_tx_buffer_swap;
  localparam logic [31:0] HDR = 32'hc0080123, CRC = 32'h000002b7, D1 = 32'ha5a50001, D2 = 32'h3c3c0002;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, go = 1'b0, as_null = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, tx_rd_data, sts_val, got_hdr, got_d0, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  hold_cyc = 8'h10;
  logic [5:0]  tx_rd_idx;
  logic        hready, hreadyout, hresp, tx_req, tx_null, tx_done, sts_we, sts_ctrl, busy;
  logic        tx_grant, tx_locked, tx_capable, host_evt, ctrl_evt, swap_busy;
  int          errors = 0, check_count = 0, cyc = 0;

  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;

  dtbs_core #(.DATA_WORDS(8)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .tx_req(tx_req), .tx_null(tx_null), .tx_done(tx_done), .tx_rd_idx(tx_rd_idx), .sts_we(sts_we),
    .sts_ctrl(sts_ctrl), .sts_val(sts_val), .tx_grant(tx_grant), .tx_locked(tx_locked),
    .tx_rd_data(tx_rd_data), .tx_capable(tx_capable), .host_evt(host_evt), .ctrl_evt(ctrl_evt),
    .swap_busy(swap_busy));

  dtbs_engine_model u_eng (
    .hclk(hclk), .hresetn(hresetn), .go(go), .as_null(as_null), .hold_cyc(hold_cyc), .tx_grant(tx_grant),
    .tx_rd_data(tx_rd_data), .tx_req(tx_req), .tx_null(tx_null), .tx_done(tx_done), .sts_we(sts_we),
    .sts_ctrl(sts_ctrl), .busy(busy), .tx_rd_idx(tx_rd_idx), .sts_val(sts_val), .got_hdr(got_hdr),
    .got_d0(got_d0));

  // hang guard, well above the few hundred cycles needed
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(hresp, 1'b0)
  endtask

  task automatic wait_swap();
    for (int i = 0; i < 300 && swap_busy === 1'b1; i++) @(posedge hclk);
    `CHK(swap_busy, 1'b0)
  endtask

  task automatic t_config();
    rchk(12'h000, {24'h0, dtbs_pkg::CS_RESET});
    rchk(12'h3f0, 32'h0);
    `CHK(tx_capable, 1'b0)
    xfer(1'b1, 12'h000, 32'h11);
    rchk(12'h000, 32'h10);
    xfer(1'b1, 12'h008, HDR);
    rchk(12'h200, HDR);
    xfer(1'b1, 12'h004, 32'hff);
    rchk(12'h004, 32'h10);
    `CHK(tx_capable, 1'b1)
    $display("config test done");
  endtask

  task automatic t_swap();
    xfer(1'b1, 12'h000, 32'h11);
    rchk(12'h000, 32'h11);
    xfer(1'b1, 12'h100, D1);
    xfer(1'b1, 12'h00c, CRC);
    xfer(1'b1, 12'h000, 32'h12);
    xfer(1'b1, 12'h000, 32'h13);
    xfer(1'b1, 12'h000, 32'h11);
    xfer(1'b0, 12'h000, 32'h0);
    `CHK(rd[1:0], 2'h2)
    `CHK(swap_busy, 1'b1)
    wait_swap();
    rchk(12'h004, 32'h16);
    rchk(12'h20c, D1);
    rchk(12'h100, D1);
    rchk(12'h00c, CRC);
    rchk(12'h008, HDR);
    rchk(12'h000, 32'h10);
    $display("swap test done");
  endtask

  // host edits while the engine sends
  task automatic t_concurrent();
    hold_cyc <= 8'h28;
    as_null <= 1'b0;
    go <= 1'b1;
    xfer(1'b1, 12'h000, 32'h11);
    go <= 1'b0;
    rchk(12'h000, 32'h11);
    xfer(1'b1, 12'h100, D2);
    xfer(1'b1, 12'h000, 32'h12);
    xfer(1'b1, 12'h000, 32'h13);
    xfer(1'b1, 12'h000, 32'h11);
    rchk(12'h000, 32'h16);
    `CHK(swap_busy, 1'b1)
    for (int i = 0; i < 200 && busy === 1'b1; i++) @(posedge hclk);
    `CHK(got_hdr, HDR)
    `CHK(got_d0, D1)
    wait_swap();
    rchk(12'h000, 32'h1c);
    `CHK(host_evt, 1'b1)
    `CHK(ctrl_evt, 1'b0)
    rchk(12'h20c, D2);
    rchk(12'h010, 32'h5a5a5a28);
    $display("concurrent test done");
  endtask

  // null frame and locked-out data write
  task automatic t_null();
    hold_cyc <= 8'h09;
    as_null <= 1'b1;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
    for (int i = 0; i < 200 && busy === 1'b1; i++) @(posedge hclk);
    `CHK(ctrl_evt, 1'b0)
    rchk(12'h004, 32'h16);
    rchk(12'h208, 32'h5a5a5a09);
    xfer(1'b1, 12'h100, D1);
    rchk(12'h100, D2);
    xfer(1'b1, 12'h000, 32'h11);
    rchk(12'h000, 32'h1d);
    $display("null test done");
  endtask

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_config();
    t_swap();
    t_concurrent();
    t_null();
    close_out();
  end
endmodule // tb_double_tx_buffer_swap
